// [src/scard_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module scard_fifo (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Write side
    input wire logic push,
    input wire logic [scard_pkg::CHAR_W-1:0] wdata,
    // Read side
    input wire logic pop,
    output logic [scard_pkg::CHAR_W-1:0] rdata,
    // Level
    output logic [scard_pkg::FIFO_AW:0] count,
    output logic full,
    output logic empty
);
    logic [scard_pkg::CHAR_W-1:0] mem [scard_pkg::FIFO_DEPTH];
    logic [scard_pkg::FIFO_AW-1:0] wp;
    logic [scard_pkg::FIFO_AW-1:0] rp;
    wire do_push = push & ~full;
    wire do_pop = pop & ~empty;
    assign full = count == 5'(scard_pkg::FIFO_DEPTH);
    assign empty = count == '0;
    assign rdata = mem[rp];
    always_ff @(posedge clk) begin
        if (do_push) begin
            mem[wp] <= wdata;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp <= '0;
            rp <= '0;
            count <= '0;
        end else begin
            wp <= wp + 4'(do_push);
            rp <= rp + 4'(do_pop);
            count <= count + 5'(do_push) - 5'(do_pop);
        end
    end
endmodule

module scard_ctrl #(
    parameter int ATR_WAIT = 40000
) (
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Card contacts
    output logic card_power_enable,
    output logic card_reset,
    output logic card_clock,
    output logic card_serial_out,
    input wire logic card_serial_in,
    // Sequence status
    output logic seq_busy
);
    localparam logic [15:0] ATR_LIM = 16'(ATR_WAIT);

    //--------------------------------------------------------------
    // Register bus
    //--------------------------------------------------------------
    logic act_en;
    logic [2:0] ctl_mode;
    logic [15:0] baud;
    logic [4:0] flags;
    scard_pkg::scard_state_t state, next_state;
    scard_pkg::scard_pins_t pins, next_pins;
    logic [7:0] tx_head, rx_head;
    logic [4:0] tx_count, rx_count;
    logic tx_full, tx_empty, rx_full, rx_empty;
    wire [4:0] flag_set;
    logic atr_fail;

    wire setup = psel & ~penable;
    wire wr = psel & penable & pready & pwrite;
    wire rd = psel & penable & pready & ~pwrite;
    wire hit = paddr == scard_pkg::ADDR_TX || paddr == scard_pkg::ADDR_RX ||
               paddr == scard_pkg::ADDR_STS0 || paddr == scard_pkg::ADDR_STS1 ||
               paddr == scard_pkg::ADDR_ICLR || paddr == scard_pkg::ADDR_CTRL0 ||
               paddr == scard_pkg::ADDR_CTRL1 || paddr == scard_pkg::ADDR_BAUD;
    wire wr_ctl0 = wr && paddr == scard_pkg::ADDR_CTRL0;
    wire act_cmd = wr_ctl0 & pwdata[scard_pkg::CTL0_ACT_CMD];
    wire deact_cmd = wr_ctl0 & pwdata[scard_pkg::CTL0_DEACT_CMD];
    wire rst_cmd = wr_ctl0 & pwdata[scard_pkg::CTL0_RST_CMD];
    wire tx_push = wr && paddr == scard_pkg::ADDR_TX;
    wire rx_pop = rd && paddr == scard_pkg::ADDR_RX;
    wire [4:0] flag_clr = (wr && paddr == scard_pkg::ADDR_ICLR) ? pwdata[4:0] : 5'h00;
    wire [31:0] sts0 = {27'h0, flags[4:1], seq_busy};
    wire [31:0] sts1 = {11'h0, card_reset, state, 3'h0, rx_count, 3'h0, tx_count};
    wire [31:0] rdata_mux =
        paddr == scard_pkg::ADDR_RX ? {24'h0, rx_head} :
        paddr == scard_pkg::ADDR_STS0 ? sts0 :
        paddr == scard_pkg::ADDR_STS1 ? sts1 :
        paddr == scard_pkg::ADDR_CTRL0 ? {18'h0, act_en, 13'h0} :
        paddr == scard_pkg::ADDR_CTRL1 ? {21'h0, ctl_mode, 8'h0} :
        paddr == scard_pkg::ADDR_BAUD ? {16'h0, baud} : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= setup;
            pslverr <= setup & ~hit;
            prdata <= setup ? rdata_mux : prdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_en <= 1'b0;
            ctl_mode <= 3'h0;
            baud <= scard_pkg::BAUD_RESET;
            flags <= 5'h00;
        end else begin
            if (wr_ctl0) begin
                act_en <= pwdata[scard_pkg::CTL0_ACT_EN];
            end
            if (wr && paddr == scard_pkg::ADDR_CTRL1) begin
                ctl_mode <= pwdata[scard_pkg::CTL1_MODE_LSB +: 3];
            end
            if (wr && paddr == scard_pkg::ADDR_BAUD) begin
                baud <= (pwdata[15:0] == 16'h0) ? 16'h0001 : pwdata[15:0];
            end
            flags <= (flags & ~flag_clr) | flag_set;
        end
    end

    //--------------------------------------------------------------
    // Card clock divider and cycle counter
    //--------------------------------------------------------------
    logic [7:0] dv_cnt;
    logic dv_phase;
    logic [15:0] atr_cnt;
    logic cnt_clr;
    wire [7:0] half_lim = (8'h01 << ctl_mode) - 8'h01;
    wire dv_wrap = dv_cnt >= half_lim;
    wire step_tick = dv_wrap & dv_phase;
    wire ck_edge = dv_wrap & ~dv_phase & pins.clk_run;
    wire atr_done = atr_cnt >= ATR_LIM;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dv_cnt <= 8'h00;
            dv_phase <= 1'b0;
            atr_cnt <= 16'h0;
        end else begin
            dv_cnt <= dv_wrap ? 8'h00 : dv_cnt + 8'h01;
            dv_phase <= dv_wrap ? ~dv_phase : dv_phase;
            if (cnt_clr) begin
                atr_cnt <= 16'h0;
            end else if (ck_edge && atr_cnt != 16'hffff) begin
                atr_cnt <= atr_cnt + 16'h0001;
            end
        end
    end

    //--------------------------------------------------------------
    // Activation, reset and deactivation sequencer
    //--------------------------------------------------------------
    logic din_q;
    // Answer start is a falling edge once the card had time to release the line
    wire atr_seen = din_q & ~card_serial_in && atr_cnt >= scard_pkg::IO_SETTLE_CYC;
    wire powered = state != scard_pkg::ST_OFF;
    wire in_deact = state == scard_pkg::ST_DEA_RST || state == scard_pkg::ST_DEA_CLK ||
                    state == scard_pkg::ST_DEA_IO;
    assign flag_set[0] = 1'b0;
    assign flag_set[scard_pkg::FLG_ATR_FAIL] = atr_fail;

    always_comb begin
        next_state = state;
        next_pins = pins;
        cnt_clr = 1'b0;
        atr_fail = 1'b0;
        if (deact_cmd && powered && !in_deact) begin
            next_state = scard_pkg::ST_DEA_RST;
            next_pins.rst = 1'b0;
        end else if (rst_cmd && (state == scard_pkg::ST_ON || state == scard_pkg::ST_WAIT_H ||
                                 state == scard_pkg::ST_WAIT_L)) begin
            next_state = scard_pkg::ST_WAIT_L;
            next_pins.rst = 1'b0;
            cnt_clr = 1'b1;
        end else begin
            case (state)
                scard_pkg::ST_OFF: begin
                    if (act_cmd && act_en) begin
                        next_state = scard_pkg::ST_ACT_RST;
                        next_pins.rst = 1'b0;
                    end
                end
                scard_pkg::ST_ACT_RST: begin
                    if (step_tick) begin
                        next_state = scard_pkg::ST_ACT_PWR;
                        next_pins.power = 1'b1;
                    end
                end
                scard_pkg::ST_ACT_PWR: begin
                    if (step_tick) begin
                        next_state = scard_pkg::ST_ACT_IO;
                        next_pins.dout = 1'b1;
                    end
                end
                scard_pkg::ST_ACT_IO: begin
                    if (step_tick) begin
                        next_state = scard_pkg::ST_WAIT_L;
                        next_pins.clk_run = 1'b1;
                        cnt_clr = 1'b1;
                    end
                end
                scard_pkg::ST_WAIT_L: begin
                    if (atr_seen) begin
                        next_state = scard_pkg::ST_ON;
                    end else if (atr_done) begin
                        next_state = scard_pkg::ST_WAIT_H;
                        next_pins.rst = 1'b1;
                        cnt_clr = 1'b1;
                    end
                end
                scard_pkg::ST_WAIT_H: begin
                    if (atr_seen) begin
                        next_state = scard_pkg::ST_ON;
                    end else if (atr_done) begin
                        next_state = scard_pkg::ST_DEA_RST;
                        next_pins.rst = 1'b0;
                        atr_fail = 1'b1;
                    end
                end
                scard_pkg::ST_ON: begin
                    next_state = scard_pkg::ST_ON;
                end
                scard_pkg::ST_DEA_RST: begin
                    if (step_tick) begin
                        next_state = scard_pkg::ST_DEA_CLK;
                        next_pins.clk_run = 1'b0;
                    end
                end
                scard_pkg::ST_DEA_CLK: begin
                    if (step_tick) begin
                        next_state = scard_pkg::ST_DEA_IO;
                        next_pins.dout = 1'b0;
                    end
                end
                scard_pkg::ST_DEA_IO: begin
                    if (step_tick) begin
                        next_state = scard_pkg::ST_OFF;
                        next_pins.power = 1'b0;
                    end
                end
                default: begin
                    next_state = scard_pkg::ST_OFF;
                    next_pins = '0;
                end
            endcase
        end
    end

    //--------------------------------------------------------------
    // Character transmitter with error-signal retransmission
    //--------------------------------------------------------------
    logic tx_on, tx_nack;
    logic [3:0] tx_bit;
    logic [15:0] tx_etu;
    logic [2:0] tx_try;
    logic rx_on;
    wire tx_etu_end = tx_etu >= baud - 16'h0001;
    wire [9:0] tx_frame = {^tx_head, tx_head, 1'b0};
    wire tx_start = ~tx_on & ~rx_on & ~tx_empty & din_q && state == scard_pkg::ST_ON;
    wire tx_last = tx_on & tx_etu_end && tx_bit == scard_pkg::GUARD_BIT;
    wire tx_retry = tx_last & tx_nack && tx_try < scard_pkg::TX_RETRY_MAX;
    wire tx_pop = tx_last & ~tx_retry;
    wire tx_level = (tx_on && tx_bit <= scard_pkg::FRAME_LAST) ? tx_frame[tx_bit] : 1'b1;
    assign flag_set[scard_pkg::FLG_TX_ERR] = tx_pop & tx_nack;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_on <= 1'b0;
            tx_nack <= 1'b0;
            tx_bit <= 4'h0;
            tx_etu <= 16'h0;
            tx_try <= 3'h0;
        end else if (tx_start) begin
            tx_on <= 1'b1;
            tx_bit <= 4'h0;
            tx_etu <= 16'h0;
        end else if (tx_on) begin
            tx_etu <= tx_etu_end ? 16'h0 : tx_etu + 16'h0001;
            if (tx_etu_end) begin
                tx_bit <= tx_retry ? 4'h0 : tx_bit + 4'h1;
                if (tx_bit == scard_pkg::ERR_BIT) begin
                    tx_nack <= ~card_serial_in;
                end
            end
            if (tx_last) begin
                tx_on <= tx_retry;
                tx_try <= tx_retry ? tx_try + 3'h1 : 3'h0;
            end
        end
    end

    //--------------------------------------------------------------
    // Character receiver
    //--------------------------------------------------------------
    logic [3:0] rx_bit;
    logic [15:0] rx_etu;
    logic [8:0] rx_sh;
    wire rx_etu_end = rx_etu >= baud - 16'h0001;
    wire rx_start = ~rx_on & ~tx_on & din_q & ~card_serial_in & pins.dout &&
                    (state == scard_pkg::ST_ON || state == scard_pkg::ST_WAIT_L ||
                     state == scard_pkg::ST_WAIT_H);
    wire [9:0] rx_frame = {card_serial_in, rx_sh};
    wire rx_done = rx_on & rx_etu_end && rx_bit == scard_pkg::FRAME_LAST;
    wire rx_good = ~rx_frame[0] & ~(^rx_frame[9:1]);
    assign flag_set[scard_pkg::FLG_RX_PAR] = rx_done & ~rx_good;
    assign flag_set[scard_pkg::FLG_RX_OVR] = rx_done & rx_good & rx_full;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_on <= 1'b0;
            rx_bit <= 4'h0;
            rx_etu <= 16'h0;
            rx_sh <= 9'h000;
        end else if (rx_start) begin
            rx_on <= 1'b1;
            rx_bit <= 4'h0;
            rx_etu <= baud >> 1;
        end else if (rx_on) begin
            rx_etu <= rx_etu_end ? 16'h0 : rx_etu + 16'h0001;
            if (rx_etu_end) begin
                rx_sh <= rx_frame[9:1];
                rx_bit <= rx_bit + 4'h1;
                rx_on <= ~rx_done;
            end
        end
    end

    scard_fifo u_tx_fifo (
        .clk(pclk), .rst_n(presetn), .push(tx_push), .wdata(pwdata[7:0]),
        .pop(tx_pop), .rdata(tx_head), .count(tx_count), .full(tx_full), .empty(tx_empty)
    );
    scard_fifo u_rx_fifo (
        .clk(pclk), .rst_n(presetn), .push(rx_done & rx_good), .wdata(rx_frame[8:1]),
        .pop(rx_pop), .rdata(rx_head), .count(rx_count), .full(rx_full), .empty(rx_empty)
    );

    //--------------------------------------------------------------
    // State and pad registers
    //--------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= scard_pkg::ST_OFF;
            pins <= '0;
            din_q <= 1'b0;
            seq_busy <= 1'b0;
            card_power_enable <= 1'b0;
            card_reset <= 1'b0;
            card_clock <= 1'b0;
            card_serial_out <= 1'b0;
        end else begin
            state <= next_state;
            pins <= next_pins;
            din_q <= card_serial_in;
            seq_busy <= next_state != scard_pkg::ST_OFF && next_state != scard_pkg::ST_ON;
            card_power_enable <= next_pins.power;
            card_reset <= next_pins.rst;
            card_clock <= next_pins.clk_run & (dv_wrap ? ~dv_phase : dv_phase);
            card_serial_out <= next_pins.dout & tx_level;
        end
    end

    //--------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------
    sequence s_deact_step;
        state == scard_pkg::ST_DEA_RST ##0 step_tick;
    endsequence
    sequence s_nack_seen;
        tx_on && tx_bit == scard_pkg::ERR_BIT && tx_etu_end && !card_serial_in;
    endsequence
    property p_clk_div;
        @(posedge pclk) disable iff (!presetn)
        $rose(card_clock) && ctl_mode == 3'h1 && pins.clk_run |=> card_clock ##1 !card_clock;
    endproperty
    a_clk_div: assert property (p_clk_div) else $error("card clock not divided by four");
    property p_act_order;
        @(posedge pclk) disable iff (!presetn)
        $rose(card_power_enable) |-> !card_reset && !card_clock && !card_serial_out;
    endproperty
    a_act_order: assert property (p_act_order) else $error("power up out of order");
    property p_act_en;
        @(posedge pclk) disable iff (!presetn)
        state == scard_pkg::ST_OFF && act_cmd && !act_en |=> state == scard_pkg::ST_OFF;
    endproperty
    a_act_en: assert property (p_act_en) else $error("activation while disabled");
    property p_act_start;
        @(posedge pclk) disable iff (!presetn)
        state == scard_pkg::ST_OFF && act_cmd && act_en |=> state == scard_pkg::ST_ACT_RST ##1 seq_busy;
    endproperty
    a_act_start: assert property (p_act_start) else $error("activation not launched");
    property p_deact_order;
        @(posedge pclk) disable iff (!presetn)
        s_deact_step |=> !card_clock && !card_reset && card_power_enable;
    endproperty
    a_deact_order: assert property (p_deact_order) else $error("deactivation out of order");
    property p_rst_hold;
        @(posedge pclk) disable iff (!presetn)
        $rose(card_reset) |-> $past(atr_cnt) >= ATR_LIM;
    endproperty
    a_rst_hold: assert property (p_rst_hold) else $error("reset released early");
    property p_atr_fail;
        @(posedge pclk) disable iff (!presetn)
        state == scard_pkg::ST_WAIT_H && atr_done && !atr_seen && !deact_cmd && !rst_cmd
        |=> state == scard_pkg::ST_DEA_RST && !card_reset;
    endproperty
    a_atr_fail: assert property (p_atr_fail) else $error("no deactivation after timeout");
    property p_keep_rst;
        @(posedge pclk) disable iff (!presetn)
        state == scard_pkg::ST_ON && !rst_cmd && !deact_cmd |=> $stable(card_reset);
    endproperty
    a_keep_rst: assert property (p_keep_rst) else $error("reset level changed");
    property p_retx;
        @(posedge pclk) disable iff (!presetn)
        tx_last && tx_nack && tx_try < scard_pkg::TX_RETRY_MAX |=> tx_on && tx_bit == 4'h0 && tx_etu == 16'h0;
    endproperty
    a_retx: assert property (p_retx) else $error("no retransmission");
    property p_nack;
        @(posedge pclk) disable iff (!presetn)
        s_nack_seen |=> tx_nack;
    endproperty
    a_nack: assert property (p_nack) else $error("error signal missed");
    property p_fifo;
        @(posedge pclk) disable iff (!presetn)
        tx_count <= 5'(scard_pkg::FIFO_DEPTH) && rx_count <= 5'(scard_pkg::FIFO_DEPTH);
    endproperty
    a_fifo: assert property (p_fifo) else $error("fifo level overflow");
endmodule
`default_nettype wire

// [src/scard_pkg.sv]
// Overview of operation
// - Card clock is system clock divided by 2^(mode+1)
// - Baud rate set by separate divider register
// - Only T=0 half-duplex characters on one line
// - Sixteen by eight transmit and receive FIFOs
// - Power, reset, clock, serial in/out pads
// - Software programs block through APB slave
// - Activation: reset low, power, receive, clock
// - Activation only while enable bit is set
// - Control zero bit 11 starts activation
// - Deactivation: reset, clock, I/O low, power
// - Deactivation command bit starts deactivation
// - Deactivate contacts when exchange is aborted
// - Reset low 40000 clocks, then drive high
// - No answer with reset high: low, deactivate
// - Keep reset level where answer appeared
// - Software may request card reset in wait or on states
// - Character is start, eight data, parity
// - Sample line eleven etu after start; retransmit
package scard_pkg;
    localparam logic [7:0] ADDR_TX = 8'h00;
    localparam logic [7:0] ADDR_RX = 8'h04;
    localparam logic [7:0] ADDR_STS0 = 8'h08;
    localparam logic [7:0] ADDR_STS1 = 8'h0c;
    localparam logic [7:0] ADDR_ICLR = 8'h14;
    localparam logic [7:0] ADDR_CTRL0 = 8'h18;
    localparam logic [7:0] ADDR_CTRL1 = 8'h1c;
    localparam logic [7:0] ADDR_BAUD = 8'h20;
    localparam int CTL0_ACT_CMD = 11;
    localparam int CTL0_DEACT_CMD = 12;
    localparam int CTL0_ACT_EN = 13;
    localparam int CTL0_RST_CMD = 14;
    localparam int CTL1_MODE_LSB = 8;
    localparam int STS1_RX_LSB = 8;
    localparam int STS1_ST_LSB = 16;
    localparam int STS1_RST_BIT = 20;
    localparam logic [15:0] BAUD_RESET = 16'h0100;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_AW = 4;
    localparam int CHAR_W = 8;
    localparam logic [3:0] FRAME_LAST = 4'h9;
    localparam logic [3:0] ERR_BIT = 4'ha;
    localparam logic [3:0] GUARD_BIT = 4'hb;
    localparam logic [2:0] TX_RETRY_MAX = 3'h3;
    localparam logic [15:0] IO_SETTLE_CYC = 16'h00c8;
    // Sticky status flags in status zero, cleared by writing one to the clear register
    localparam int FLG_ATR_FAIL = 1;
    localparam int FLG_TX_ERR = 2;
    localparam int FLG_RX_PAR = 3;
    localparam int FLG_RX_OVR = 4;
    typedef enum logic [3:0] {
        ST_OFF = 4'h0, ST_ACT_RST = 4'h1, ST_ACT_PWR = 4'h2, ST_ACT_IO = 4'h3,
        ST_WAIT_L = 4'h4, ST_WAIT_H = 4'h5, ST_ON = 4'h6,
        ST_DEA_RST = 4'h7, ST_DEA_CLK = 4'h8, ST_DEA_IO = 4'h9
    } scard_state_t;
    typedef struct packed {
        logic power;
        logic rst;
        logic clk_run;
        logic dout;
    } scard_pins_t;
endpackage

// [bench/scard_card_model.sv]
`timescale 1ns/1ps
`default_nettype none
module scard_card_model (
    // Contacts
    input wire logic card_power_enable,
    input wire logic card_reset,
    input wire logic card_clock,
    input wire logic card_serial_out,
    output logic card_serial_in,
    // Answer while reset is low (01), high (10), or never (00)
    input wire logic [1:0] answer_mode,
    // Error signal forced onto the line by the bench
    input wire logic nack_req
);
    logic last_rst = 1'b0;
    int edges = 0;
    int pull = 0;
    // Pull-up keeps the line high unless a party drives it low
    assign card_serial_in = card_serial_out & (pull == 0) & ~nack_req;
    always @(posedge card_power_enable) edges = 0;
    always @(posedge card_clock) begin
        if (card_reset !== last_rst) begin
            edges <= 0;
            last_rst <= card_reset;
        end else begin
            edges <= edges + 1;
        end
        if (pull > 0) begin
            pull <= pull - 1;
        end else if (edges == 250 && answer_mode == {card_reset, !card_reset}) begin
            pull <= 40;
        end
    end
endmodule
`default_nettype wire

// [bench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // ------------------------------------------
    // Clock, reset, APB master and scenarios
    // ------------------------------------------
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er, seq_busy;
    logic card_power_enable, card_reset, card_clock, card_serial_out, card_serial_in;
    logic [1:0] answer_mode = 2'h0;
    logic nack_req = 1'b0;
    int bad_count = 0;
    int compares = 0;
    int n1, n2;
    always #5 pclk = ~pclk;
    scard_ctrl #(.ATR_WAIT(300)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .card_power_enable, .card_reset, .card_clock, .card_serial_out, .card_serial_in, .seq_busy);
    scard_card_model card_u (.card_power_enable, .card_reset, .card_clock, .card_serial_out, .card_serial_in,
        .answer_mode, .nack_req);
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic pin(input int k);
        case (k)
            0: return card_power_enable;
            1: return card_serial_out;
            2: return card_reset;
            3: return card_clock;
            default: return seq_busy;
        endcase
    endfunction
    task await(input int k, input logic v, input int lim, output int n);
        for (n = 0; n < lim && pin(k) !== v; n++) @(posedge pclk);
        chk("pin wait", {31'h0, v}, {31'h0, pin(k)});
    endtask
    task print_verdict;
        $display("comparisons %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task t_regs;
        chk("idle pins", 4'h0, {card_power_enable, card_reset, card_clock, card_serial_out});
        apb(1'b0, 8'h20, 32'h0);
        chk("baud reset", 32'h100, rd);
        apb(1'b1, 8'h20, 32'h1234);
        apb(1'b0, 8'h20, 32'h0);
        chk("baud", 32'h1234, rd);
        apb(1'b0, 8'h24, 32'h0);
        chk("unmapped", 32'h1, {31'h0, er});
        apb(1'b1, 8'h1c, 32'h100);
        apb(1'b1, 8'h18, 32'h800);
        apb(1'b0, 8'h0c, 32'h0);
        chk("no enable", 32'h0, {28'h0, rd[19:16]});
        $display("registers done");
    endtask
    task t_activate;
        answer_mode <= 2'h2;
        apb(1'b1, 8'h20, 32'h4);
        apb(1'b1, 8'h18, 32'h2000);
        apb(1'b1, 8'h18, 32'h2800);
        await(4, 1'b1, 8, n1);
        await(0, 1'b1, 100, n1);
        chk("act power", 3'h0, {card_reset, card_clock, card_serial_out});
        await(1, 1'b1, 100, n1);
        chk("act gap", 1, {31'h0, n1 >= 4});
        chk("act receive", 2'h1, {card_clock, card_power_enable});
        await(3, 1'b1, 100, n1);
        await(3, 1'b0, 10, n1);
        await(3, 1'b1, 10, n2);
        chk("clock period", 4, n1 + n2);
        await(2, 1'b1, 2000, n1);
        chk("reset low span", 1, {31'h0, n1 >= 1150});
        await(4, 1'b0, 2000, n1);
        repeat (60) @(posedge pclk);
        apb(1'b0, 8'h0c, 32'h0);
        chk("on state", 32'h16, {27'h0, rd[20:16]});
        chk("rx count", 32'h1, {27'h0, rd[12:8]});
        apb(1'b0, 8'h04, 32'h0);
        chk("rx byte", 32'h0, rd);
        $display("activation done");
    endtask
    task t_reset_cmd;
        answer_mode <= 2'h1;
        apb(1'b1, 8'h18, 32'h6000);
        await(2, 1'b0, 10, n1);
        await(4, 1'b0, 3000, n1);
        apb(1'b0, 8'h0c, 32'h0);
        chk("kept low", 32'h06, {27'h0, rd[20:16]});
        $display("card reset done");
    endtask
    task t_tx;
        apb(1'b1, 8'h00, 32'h5a);
        await(1, 1'b0, 400, n1);
        repeat (40) @(posedge pclk);
        nack_req <= 1'b1;
        repeat (6) @(posedge pclk);
        nack_req <= 1'b0;
        await(1, 1'b0, 20, n1);
        repeat (80) @(posedge pclk);
        apb(1'b0, 8'h0c, 32'h0);
        chk("tx count", 32'h0, {27'h0, rd[4:0]});
        apb(1'b0, 8'h08, 32'h0);
        chk("tx error", 32'h0, {31'h0, rd[2]});
        $display("transmit done");
    endtask
    task t_deactivate;
        apb(1'b1, 8'h18, 32'h3000);
        await(1, 1'b0, 100, n1);
        chk("deact order", 3'h1, {card_reset, card_clock, card_power_enable});
        await(0, 1'b0, 100, n1);
        chk("deact gap", 1, {31'h0, n1 >= 4});
        await(4, 1'b0, 100, n1);
        $display("deactivation done");
    endtask
    task t_timeout;
        answer_mode <= 2'h0;
        apb(1'b1, 8'h18, 32'h2800);
        await(2, 1'b1, 3000, n1);
        await(0, 1'b0, 3000, n1);
        chk("timeout pins", 3'h0, {card_reset, card_clock, card_serial_out});
        apb(1'b0, 8'h08, 32'h0);
        chk("timeout flag", 32'h1, {31'h0, rd[1]});
        apb(1'b1, 8'h14, 32'h2);
        apb(1'b0, 8'h08, 32'h0);
        chk("flag cleared", 32'h0, {31'h0, rd[1]});
        $display("answer timeout done");
    endtask
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_activate();
        t_reset_cmd();
        t_tx();
        t_deactivate();
        t_timeout();
        print_verdict();
    end
    initial begin
        repeat (30000) @(posedge pclk);
        bad_count++;
        print_verdict();
    end
endmodule
`default_nettype wire
